//--- src/encpc_top.sv
// Overview of operation
// - With activation follow set, laser follows the synchronised activation input level.
// - With activation follow clear (reset default), laser stays on always.
// - Cascade output stays low unless cascade mode is enabled (reset default off).
// - Two-channel encoder direction comes from phase of B at each A edge.
// - Single-channel encoder counts up while B is low, down while high.
// - Single-channel with B open counts up; B must idle low.
// - One-edge mode adds one per A pulse, on its rising edge only.
// - Both-edge mode counts both A edges, two per pulse.
// - Invert option swaps up and down counting.
// - Passing the selected maximum wraps the counter to zero and continues.
// - Full 32-bit limit applies only with both-edge evaluation.
// - Legacy limit selectable only with both-edge evaluation.
// - Half-range limit applies only, and always, with one-edge evaluation.
// - Defaults are two-channel, both-edge, full limit.
`timescale 1ns/100ps
`default_nettype none

module encpc_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // APB slave
   input wire encpc_pkg::encpc_apb_req_t apb_req,
   output encpc_pkg::encpc_apb_rsp_t apb_rsp,
   // Incremental input connector pins
   input wire logic enc_a,
   input wire logic enc_b,
   // Laser activation
   input wire logic activation_in,
   output logic laser_on,
   // Cascading trigger
   input wire logic meas_trig,
   output logic cascade_out,
   // Counter value towards the frame header logic
   output logic [31:0] enc_count
);
   import encpc_pkg::*;

   typedef struct packed {
      encpc_ctrl_t ctrl;
      logic [31:0] count;
      logic wrapped;
      logic dir_down;
      logic laser;
      logic cascade;
      logic [31:0] rdata;
   } encpc_state_t;

   encpc_state_t st_q;
   encpc_state_t st_d;

   logic a_lvl;
   logic a_rise;
   logic a_fall;
   logic b_lvl;
   logic act_lvl;

   // Pin synchronisers
   encpc_sync_edge u_sync_a (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin(enc_a),
      .level(a_lvl),
      .rise(a_rise),
      .fall(a_fall)
   );

   encpc_sync_edge u_sync_b (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin(enc_b),
      .level(b_lvl),
      .rise(),
      .fall()
   );

   encpc_sync_edge u_sync_act (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin(activation_in),
      .level(act_lvl),
      .rise(),
      .fall()
   );

   // Effective wrap limit from the mode pair
   function automatic logic [31:0] eff_limit(input encpc_ctrl_t c);
      logic [31:0] lim;
      lim = ENCPC_LIMIT_FULL;
      if (c.eval_single) begin
         lim = ENCPC_LIMIT_HALF;
      end else if (c.wrap_sel == ENCPC_WRAP_COMPAT) begin
         lim = ENCPC_LIMIT_COMPAT;
      end else begin
         lim = ENCPC_LIMIT_FULL;
      end
      return lim;
   endfunction

   // Read-back of the control register, reserved bits zero
   function automatic logic [31:0] ctrl_word(input encpc_ctrl_t c);
      return {{(32 - ENCPC_CTRL_W){1'b0}}, c};
   endfunction

   // Decode and bus strobes
   logic [ENCPC_AW-1:0] addr;
   logic hit_ctrl;
   logic hit_count;
   logic hit_status;
   logic hit_cmd;
   logic mapped;
   logic setup;
   logic access;
   logic wr;

   assign addr = apb_req.paddr[ENCPC_AW-1:0];
   assign hit_ctrl = (apb_req.paddr[31:ENCPC_AW] == '0) && (addr == ENCPC_OFF_CTRL);
   assign hit_count = (apb_req.paddr[31:ENCPC_AW] == '0) && (addr == ENCPC_OFF_COUNT);
   assign hit_status = (apb_req.paddr[31:ENCPC_AW] == '0) && (addr == ENCPC_OFF_STATUS);
   assign hit_cmd = (apb_req.paddr[31:ENCPC_AW] == '0) && (addr == ENCPC_OFF_CMD);
   assign mapped = hit_ctrl | hit_count | hit_status | hit_cmd;
   assign setup = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable;
   assign wr = access & apb_req.pwrite & mapped;

   // Counting event, direction and step
   logic cnt_evt;
   logic raw_down;
   logic cnt_down;
   logic [1:0] step;
   logic [31:0] limit;
   logic [32:0] sum_up;
   logic [32:0] sum_dn;
   logic [31:0] cnt_next;
   logic cnt_wrap;

   always_comb begin
      if (st_q.ctrl.eval_single) begin
         cnt_evt = a_rise;
         step = ENCPC_STEP_ONE;
      end else begin
         cnt_evt = a_rise | a_fall;
         // One per edge, so a whole pulse adds two
         step = ENCPC_STEP_ONE;
      end
   end

   always_comb begin
      if (st_q.ctrl.enc_single) begin
         // Open B reads low through the connector pull-down: count up
         raw_down = b_lvl;
      end else if (a_rise) begin
         // A leading B: B still low at the A rise when moving forward
         raw_down = b_lvl;
      end else begin
         raw_down = ~b_lvl;
      end
      cnt_down = raw_down ^ st_q.ctrl.invert;
   end

   // Wrap arithmetic, one bit wider so the limit plus one is exact
   always_comb begin
      limit = eff_limit(st_q.ctrl);
      sum_up = {1'b0, st_q.count} + {31'h0, step};
      sum_dn = {1'b0, limit} + 33'h0_0000_0001 + {1'b0, st_q.count} - {31'h0, step};
      cnt_wrap = 1'b0;
      if (cnt_down) begin
         if (st_q.count < {30'h0, step}) begin
            cnt_next = sum_dn[31:0];
            cnt_wrap = 1'b1;
         end else begin
            cnt_next = st_q.count - {30'h0, step};
         end
      end else begin
         if (sum_up > {1'b0, limit}) begin
            // Whatever passes the limit carries on from zero
            cnt_next = 32'(sum_up - {1'b0, limit} - 33'h0_0000_0001);
            cnt_wrap = 1'b1;
         end else begin
            cnt_next = sum_up[31:0];
         end
      end
   end

   // Next state
   always_comb begin
      st_d = st_q;

      // Encoder counter
      if (cnt_evt) begin
         st_d.count = cnt_next;
         st_d.dir_down = cnt_down;
      end

      // Control register write
      if (wr && hit_ctrl) begin
         st_d.ctrl = encpc_ctrl_t'(apb_req.pwdata[ENCPC_CTRL_W-1:0]);
      end

      // Commands; a clear beats a simultaneous count
      if (wr && hit_cmd) begin
         if (apb_req.pwdata[ENCPC_CMD_CLR_COUNT]) begin
            st_d.count = ENCPC_COUNT_RST;
         end
         if (apb_req.pwdata[ENCPC_CMD_CLR_WRAP]) begin
            st_d.wrapped = 1'b0;
         end
         if (apb_req.pwdata[ENCPC_CMD_DEFAULTS]) begin
            st_d.ctrl = ENCPC_CTRL_RST;
            st_d.count = ENCPC_COUNT_RST;
         end
      end

      // Sticky wrap flag: a wrap in the clearing cycle still sets it
      if (cnt_evt && cnt_wrap) begin
         st_d.wrapped = 1'b1;
      end

      // Laser gating
      if (st_q.ctrl.act_follow) begin
         st_d.laser = act_lvl;
      end else begin
         st_d.laser = 1'b1;
      end

      // Cascading trigger passes only in cascade mode
      st_d.cascade = st_q.ctrl.cascade_en & meas_trig;

      // Read data latched in the setup phase, shown in the access phase
      if (setup) begin
         if (hit_ctrl) begin
            st_d.rdata = ctrl_word(st_q.ctrl);
         end else if (hit_count) begin
            st_d.rdata = st_q.count;
         end else if (hit_status) begin
            st_d.rdata = {26'h0, st_q.wrapped, st_q.dir_down, b_lvl, a_lvl,
                          st_q.cascade, st_q.laser};
         end else begin
            st_d.rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q.ctrl <= ENCPC_CTRL_RST;
         st_q.count <= ENCPC_COUNT_RST;
         st_q.wrapped <= 1'b0;
         st_q.dir_down <= 1'b0;
         st_q.laser <= 1'b1;
         st_q.cascade <= 1'b0;
         st_q.rdata <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
      end
   end

   // Zero wait states: every access completes in its first access cycle
   always_comb begin
      apb_rsp.pready = 1'b1;
      apb_rsp.pslverr = access & ~mapped;
      apb_rsp.prdata = st_q.rdata;
   end

   assign laser_on = st_q.laser;
   assign cascade_out = st_q.cascade;
   assign enc_count = st_q.count;

endmodule

`default_nettype wire

//--- src/encpc_pkg.sv
package encpc_pkg;

   // APB window and register offsets (byte addresses)
   localparam int unsigned ENCPC_AW = 8;
   localparam logic [ENCPC_AW-1:0] ENCPC_OFF_CTRL = 8'h00;
   localparam logic [ENCPC_AW-1:0] ENCPC_OFF_COUNT = 8'h04;
   localparam logic [ENCPC_AW-1:0] ENCPC_OFF_STATUS = 8'h08;
   localparam logic [ENCPC_AW-1:0] ENCPC_OFF_CMD = 8'h0c;

   // Command register bit positions (write only, self clearing)
   localparam int unsigned ENCPC_CMD_CLR_COUNT = 0;
   localparam int unsigned ENCPC_CMD_DEFAULTS = 1;
   localparam int unsigned ENCPC_CMD_CLR_WRAP = 2;

   // Counter wrap limits
   localparam logic [31:0] ENCPC_LIMIT_FULL = 32'hffff_ffff;
   localparam logic [31:0] ENCPC_LIMIT_COMPAT = 32'hfeff_ffff;
   localparam logic [31:0] ENCPC_LIMIT_HALF = 32'h7fff_ffff;
   localparam logic [31:0] ENCPC_COUNT_RST = 32'h0000_0000;

   // Counter steps per counted edge
   localparam logic [1:0] ENCPC_STEP_ONE = 2'h1;
   localparam logic [1:0] ENCPC_STEP_TWO = 2'h2;

   typedef enum logic [1:0] {
      ENCPC_WRAP_FULL = 2'h0,
      ENCPC_WRAP_COMPAT = 2'h1,
      ENCPC_WRAP_HALF = 2'h2
   } encpc_wrap_t;

   // Control register layout, bit 0 upward: act_follow, cascade_en,
   // enc_single, eval_single, invert, wrap_sel[1:0]; bits above read zero
   typedef struct packed {
      encpc_wrap_t wrap_sel;
      logic invert;
      logic eval_single;
      logic enc_single;
      logic cascade_en;
      logic act_follow;
   } encpc_ctrl_t;

   localparam int unsigned ENCPC_CTRL_W = 7;
   localparam encpc_ctrl_t ENCPC_CTRL_RST = 7'h00;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } encpc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } encpc_apb_rsp_t;

   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } encpc_sync_st_t;

endpackage

//--- src/encpc_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none

module encpc_sync_edge (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Asynchronous pin
   input wire logic pin,
   // Synchronised level and one-cycle edge pulses
   output logic level,
   output logic rise,
   output logic fall
);
   import encpc_pkg::*;

   encpc_sync_st_t st_q;
   encpc_sync_st_t st_d;

   // The meta stage feeds only the sync stage
   always_comb begin
      st_d = st_q;
      st_d.meta = pin;
      st_d.sync = st_q.meta;
      st_d.last = st_q.sync;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign level = st_q.sync;
   assign rise = st_q.sync & ~st_q.last;
   assign fall = ~st_q.sync & st_q.last;

endmodule

`default_nettype wire

//--- testbench/encpc_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module encpc_asserts (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register bus
   input wire encpc_pkg::encpc_apb_req_t apb_req,
   input wire encpc_pkg::encpc_apb_rsp_t apb_rsp,
   // Pins
   input wire logic enc_a,
   input wire logic activation_in,
   input wire logic laser_on,
   input wire logic meas_trig,
   input wire logic cascade_out,
   input wire logic [31:0] enc_count
);
   import encpc_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Shadow of the control word, so the checks know the mode
   logic [6:0] ctrl_q;
   logic wr;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         ctrl_q <= 7'h0;
      else if (wr && apb_req.paddr == 32'h0)
         ctrl_q <= apb_req.pwdata[6:0];
      else if (wr && apb_req.paddr == 32'hc && apb_req.pwdata[1])
         ctrl_q <= 7'h0;
   end
   sequence acc_s; apb_req.psel && apb_req.penable; endsequence
   sequence quiet_s; $stable(enc_a) && !apb_req.psel; endsequence
   // Bus commands may also move the count, so they are left out here
   sequence moved_s; $changed(enc_count) && !$past(apb_req.psel); endsequence
   laser_on_a: assert property (!$past(ctrl_q[0]) |-> laser_on)
      else $error("laser off");
   laser_follow_a: assert property ($past(ctrl_q[0]) |->
      laser_on == $past(activation_in, 3)) else $error("laser level");
   cascade_gate_a: assert property (cascade_out ==
      ($past(meas_trig) && $past(ctrl_q[1]))) else $error("cascade");
   count_step_a: assert property (moved_s |->
      (enc_count - $past(enc_count)) inside {32'h1, 32'hffff_ffff}
      || enc_count == 32'h0 || $past(enc_count) == 32'h0) else $error("step");
   count_still_a: assert property (quiet_s [*5] |-> $stable(enc_count))
      else $error("count moved");
   one_edge_a: assert property ($fell(enc_a) && ctrl_q[3] |->
      ##2 $stable(enc_count) [*3]) else $error("fall counted");
   wrap_down_a: assert property (moved_s and ($past(enc_count) == 32'h0
      && enc_count != 32'h1) |-> enc_count == (ctrl_q[3] ? 32'h7fff_ffff :
      (ctrl_q[6:5] == 2'h1 ? 32'hfeff_ffff : 32'hffff_ffff))) else $error("limit");
   bus_err_a: assert property (acc_s |-> apb_rsp.pready && apb_rsp.pslverr ==
      !(apb_req.paddr inside {32'h0, 32'h4, 32'h8, 32'hc})) else $error("bus");
endmodule
bind encpc_top encpc_asserts chk (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .enc_a(enc_a), .activation_in(activation_in), .laser_on(laser_on),
   .meas_trig(meas_trig), .cascade_out(cascade_out), .enc_count(enc_count));
`default_nettype wire

//--- testbench/encpc_enc_model.sv
`timescale 1ns/100ps
`default_nettype none
module encpc_enc_model (
   // Clock
   input wire logic clk_sys,
   // Channels; B stands low as if pulled down when unused
   output logic enc_a,
   output logic enc_b
);
   initial begin
      enc_a = 1'b0;
      enc_b = 1'b0;
   end
   // Each level held several cycles so the synchroniser never misses it
   task automatic step(input logic a, input logic b, input int g);
      repeat (g) @(posedge clk_sys);
      enc_a <= a;
      enc_b <= b;
   endtask
   task automatic quad(input logic dn, input int n, input int g);
      step(1'b0, 1'b0, g);
      repeat (n) begin
         step(~dn, dn, g);
         step(1'b1, 1'b1, g);
         step(dn, ~dn, g);
         step(1'b0, 1'b0, g);
      end
   endtask
   task automatic single(input logic dn, input int n, input int g);
      step(1'b0, dn, g);
      repeat (n) begin
         step(1'b1, dn, g);
         step(1'b0, dn, g);
      end
   endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected %0t mismatch %h %h", $time, g, e); end end
module tb;
   import encpc_pkg::*;
   logic clk_sys, rst, act, trig, enc_a, enc_b, laser_on, casc, perr, tv, f;
   logic [31:0] cnt, rd, exp_c, lim;
   logic [15:0] seed;
   logic [6:0] c;
   logic [6:0] tbl [6] = '{7'h00, 7'h10, 7'h20, 7'h4c, 7'h5c, 7'h08};
   int err_count, compares;
   encpc_apb_req_t req;
   encpc_apb_rsp_t rsp;
   encpc_top dut (.clk_sys(clk_sys), .rst(rst), .apb_req(req), .apb_rsp(rsp), .enc_a(enc_a),
      .enc_b(enc_b), .activation_in(act), .laser_on(laser_on), .meas_trig(trig),
      .cascade_out(casc), .enc_count(cnt));
   encpc_enc_model enc (.clk_sys(clk_sys), .enc_a(enc_a), .enc_b(enc_b));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_count++;
      stop_test();
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] nxt(input logic [31:0] v, input logic dn);
      if (dn)
         return (v == 32'h0) ? lim : v - 32'h1;
      return (v == lim) ? 32'h0 : v + 32'h1;
   endfunction
   task automatic stop_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (rsp.pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         err_count++;
         stop_test();
      end
      rd = rsp.prdata;
      perr = rsp.pslverr;
      req <= '0;
   endtask
   // Pin direction is the count direction turned round when inverted
   task automatic run(input logic dn, input int k);
      if (c[2])
         enc.single(dn ^ c[4], k, 3 + seed[1:0]);
      else
         enc.quad(dn ^ c[4], k, 3 + seed[1:0]);
      repeat (c[3] ? k : 2 * k) exp_c = nxt(exp_c, dn);
      repeat (6) @(posedge clk_sys);
      apb(1'b0, 32'h4, 32'h0);
      `CHK(rd, exp_c)
      `CHK(cnt, exp_c)
   endtask
   initial begin
      rst = 1'b1;
      req = '0;
      act = 1'b0;
      trig = 1'b0;
      seed = 16'heb_ea;
      err_count = 0;
      compares = 0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, 32'h0, 32'h0);
      `CHK(rd, 32'h0)
      `CHK({laser_on, casc, cnt}, 34'h2_0000_0000)
      apb(1'b0, 32'h10, 32'h0);
      `CHK(perr, 1'b1)
      $display("test reset done");
      foreach (tbl[m]) begin
         c = tbl[m];
         lim = c[3] ? 32'h7fff_ffff : (c[6:5] == 2'h1 ? 32'hfeff_ffff : 32'hffff_ffff);
         apb(1'b1, 32'h0, {25'h0, c});
         apb(1'b1, 32'hc, 32'h1);
         exp_c = 32'h0;
         for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            run(k == 0 || seed[0], k == 0 ? 1 : 1 + seed[3:2]);
         end
         $display("test mode %0d done", m);
      end
      // Every mode opened with a wrap below zero, so the sticky flag is up
      apb(1'b0, 32'h8, 32'h0);
      `CHK(rd[5], 1'b1)
      apb(1'b1, 32'hc, 32'h4);
      apb(1'b0, 32'h8, 32'h0);
      `CHK(rd[5], 1'b0)
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         f = seed[3];
         tv = seed[1];
         apb(1'b1, 32'h0, {30'h0, seed[2], f});
         act <= seed[0];
         trig <= tv;
         @(posedge clk_sys);
         trig <= 1'b0;
         #1 `CHK(casc, tv & seed[2])
         repeat (4) @(posedge clk_sys);
         #1 `CHK(laser_on, f ? act : 1'b1)
      end
      $display("test gating done");
      apb(1'b1, 32'h0, 32'h3c);
      apb(1'b1, 32'hc, 32'h2);
      apb(1'b0, 32'h0, 32'h0);
      `CHK({rd, cnt}, 64'h0)
      $display("test defaults done");
      stop_test();
   end
endmodule
`default_nettype wire
